/* File: hw/cpu_register_set.sv */
/*
  CPU register set: general register store, status word, base pointers,
  multiply-accumulate halves, return link, program counter, address
  generation and the reset/exception stack sequencer.
  Assumes the execution datapath and memory run on CLK_SYS, hold requests
  off while BUSY is high, and answer memory requests with MEM_ACK.
*/
//
// Functional notes
// - sixteen 32-bit general registers 0..15 for data and addresses
// - register 0 is the fixed index register of indexed modes
// - register 15 is the stack pointer for the CPU's own stack
// - exception entry pushes status and pc, return pops them via sp
// - three control registers; peripheral base feeds base-relative modes
// - vector table base locates the exception vectors
// - system registers: mac high, mac low, return link, pc
// - reserved status bits read zero; software writes only zero
// - status bits 9 and 8 are divide flags, reset value undefined
// - status bits 7..4 are interrupt mask, reset to all ones
// - post-increment and pre-decrement update the address register
// - displacement mode adds a 4-bit field to a register
// - indexed mode adds register 0 and another register
// - peripheral base plus 8-bit displacement or register 0
// - branch target is pc plus disp8, disp12 or a register
// - status bit 1 is the accumulate flag, reset value undefined
// - status bit 0 is the condition flag
// - reset loads pc and sp from the vector table
`timescale 1ns/10ps
module cpu_register_set (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic CLK_EN,
  input wire logic [cpu_regs_pkg::AW-1:0] REG_ADDR,
  input wire logic [cpu_regs_pkg::XLEN-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [cpu_regs_pkg::XLEN-1:0] REG_RDATA,
  input wire logic [3:0] RD_A_SEL,
  input wire logic [3:0] RD_B_SEL,
  output logic [cpu_regs_pkg::XLEN-1:0] RD_A_DATA,
  output logic [cpu_regs_pkg::XLEN-1:0] RD_B_DATA,
  input wire logic WR_EN,
  input wire logic [3:0] WR_SEL,
  input wire logic [cpu_regs_pkg::XLEN-1:0] WR_DATA,
  input wire logic COND_WE,
  input wire logic COND_IN,
  input wire logic DIV_WE,
  input wire logic DIV_Q_IN,
  input wire logic DIV_M_IN,
  input wire logic MAC_WE,
  input wire logic [cpu_regs_pkg::XLEN-1:0] MAC_HI_IN,
  input wire logic [cpu_regs_pkg::XLEN-1:0] MAC_LO_IN,
  input wire logic LINK_WE,
  input wire logic [cpu_regs_pkg::XLEN-1:0] LINK_IN,
  input wire logic PC_STEP,
  input wire logic PC_LOAD,
  input wire logic [cpu_regs_pkg::XLEN-1:0] PC_LOAD_VAL,
  input wire logic AG_REQ,
  input wire cpu_regs_pkg::ag_mode_e AG_MODE,
  input wire logic [3:0] AG_REG,
  input wire logic [11:0] AG_DISP,
  input wire logic [1:0] AG_SIZE,
  output logic [cpu_regs_pkg::XLEN-1:0] AG_ADDR,
  output logic AG_VALID,
  input wire logic EXC_REQ,
  input wire logic [7:0] EXC_VEC,
  input wire logic EXC_RET,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [cpu_regs_pkg::XLEN-1:0] MEM_ADDR,
  output logic [cpu_regs_pkg::XLEN-1:0] MEM_WDATA,
  input wire logic MEM_ACK,
  input wire logic [cpu_regs_pkg::XLEN-1:0] MEM_RDATA,
  output logic BUSY,
  output logic [cpu_regs_pkg::XLEN-1:0] STATUS_WORD,
  output logic [cpu_regs_pkg::XLEN-1:0] PERIPH_BASE,
  output logic [cpu_regs_pkg::XLEN-1:0] VECTOR_BASE,
  output logic [cpu_regs_pkg::XLEN-1:0] MAC_HI,
  output logic [cpu_regs_pkg::XLEN-1:0] MAC_LO,
  output logic [cpu_regs_pkg::XLEN-1:0] LINK_REG,
  output logic [cpu_regs_pkg::XLEN-1:0] PC,
  output logic [cpu_regs_pkg::XLEN-1:0] SP
);
  import cpu_regs_pkg::*;

  typedef struct packed {
    seq_state_e state;
    logic [XLEN-1:0] status;
    logic [XLEN-1:0] pbp;
    logic [XLEN-1:0] vtb;
    logic [XLEN-1:0] multiply_accum_high;
    logic [XLEN-1:0] multiply_accum_low;
    logic [XLEN-1:0] link;
    logic [XLEN-1:0] pc;
    logic [XLEN-1:0] r0;
    logic [XLEN-1:0] sp;
    logic ag_pend;
    ag_mode_e ag_mode;
    logic [11:0] ag_disp;
    logic [1:0] ag_size;
    logic [XLEN-1:0] ag_addr;
    logic ag_valid;
    logic [XLEN-1:0] rdata;
    logic mem_req;
    logic mem_we;
    logic [XLEN-1:0] mem_addr;
    logic [XLEN-1:0] mem_wdata;
    logic [7:0] exc_vec;
    logic busy;
  } regs_s;

  localparam regs_s REGS_RESET = '{
    state: ST_RST_PC, status: SW_RESET, vtb: VTB_RESET, ag_mode: AG_INDIRECT,
    mem_req: 1'b1, mem_addr: VTB_RESET + VEC_PC_OFF, busy: 1'b1, default: '0};

  regs_s st;
  regs_s next_st;
  regfile_if #(.W(XLEN), .NRD(3)) rf ();
  logic [XLEN-1:0] base;
  logic [XLEN-1:0] step;
  logic [XLEN-1:0] index_sum;

  gp_reg_store #(.W(XLEN), .NREG(NREG), .NRD(3)) u_store (
    .clk(CLK_SYS),
    .resetn(RESETN),
    .rf(rf.store)
  );

  // two operand ports plus one port for the address generator
  assign rf.ce = CLK_EN;
  assign rf.rd_sel[0] = RD_A_SEL;
  assign rf.rd_sel[1] = RD_B_SEL;
  assign rf.rd_sel[2] = AG_REG;
  assign base = rf.rd_data[2];
  assign step = XLEN'(1) << st.ag_size;
  assign index_sum = st.r0 + base;

  always_comb begin
    next_st = st;
    next_st.ag_valid = 1'b0;
    next_st.rdata = '0;
    rf.wr_en = 1'b0;
    rf.wr_sel = '0;
    rf.wr_data = '0;

    // control register port, read data valid in the next cycle only
    if (REG_RD) begin
      unique case (REG_ADDR)
        OFF_STATUS: next_st.rdata = st.status & SW_WRITABLE;
        OFF_PBP: next_st.rdata = st.pbp;
        OFF_VTB: next_st.rdata = st.vtb;
        OFF_MULTIPLY_ACCUM_HIGH: next_st.rdata = st.multiply_accum_high;
        OFF_MULTIPLY_ACCUM_LOW: next_st.rdata = st.multiply_accum_low;
        OFF_LINK: next_st.rdata = st.link;
        OFF_PC: next_st.rdata = st.pc;
        OFF_SP: next_st.rdata = st.sp;
        default: next_st.rdata = '0;
      endcase
    end
    if (REG_WR) begin
      unique case (REG_ADDR)
        OFF_STATUS: next_st.status = REG_WDATA & SW_WRITABLE;
        OFF_PBP: next_st.pbp = REG_WDATA;
        OFF_VTB: next_st.vtb = REG_WDATA;
        OFF_MULTIPLY_ACCUM_HIGH: next_st.multiply_accum_high = REG_WDATA;
        OFF_MULTIPLY_ACCUM_LOW: next_st.multiply_accum_low = REG_WDATA;
        OFF_LINK: next_st.link = REG_WDATA;
        OFF_PC: next_st.pc = REG_WDATA;
        default: ;
      endcase
    end

    // datapath flag updates beat a software write in the same cycle
    if (COND_WE) begin
      next_st.status[SW_T_BIT] = COND_IN;
    end
    if (DIV_WE) begin
      next_st.status[SW_Q_BIT] = DIV_Q_IN;
      next_st.status[SW_M_BIT] = DIV_M_IN;
    end
    if (MAC_WE) begin
      next_st.multiply_accum_high = MAC_HI_IN;
      next_st.multiply_accum_low = MAC_LO_IN;
    end
    if (LINK_WE) begin
      next_st.link = LINK_IN;
    end
    if (PC_LOAD) begin
      next_st.pc = PC_LOAD_VAL;
    end else if (PC_STEP) begin
      next_st.pc = st.pc + INSN_BYTES;
    end

    // address generation: request cycle reads the register, next cycle adds
    next_st.ag_pend = AG_REQ;
    if (AG_REQ) begin
      next_st.ag_mode = AG_MODE;
      next_st.ag_disp = AG_DISP;
      next_st.ag_size = AG_SIZE;
    end
    if (st.ag_pend) begin
      next_st.ag_valid = 1'b1;
      unique case (st.ag_mode)
        AG_INDIRECT: next_st.ag_addr = base;
        AG_POSTINC: begin
          next_st.ag_addr = base;
          rf.wr_en = 1'b1;
          rf.wr_sel = AG_REG;
          rf.wr_data = base + step;
        end
        AG_PREDEC: begin
          next_st.ag_addr = base - step;
          rf.wr_en = 1'b1;
          rf.wr_sel = AG_REG;
          rf.wr_data = base - step;
        end
        AG_DISP4: next_st.ag_addr = base + (XLEN'(st.ag_disp[3:0]) << st.ag_size);
        AG_INDEX: next_st.ag_addr = index_sum;
        AG_PBP_DISP: next_st.ag_addr = st.pbp + (XLEN'(st.ag_disp[7:0]) << st.ag_size);
        AG_PBP_INDEX: next_st.ag_addr = st.pbp + st.r0;
        AG_PC_DISP8:
          next_st.ag_addr = st.pc + {{23{st.ag_disp[7]}}, st.ag_disp[7:0], 1'b0};
        AG_PC_DISP12:
          next_st.ag_addr = st.pc + {{19{st.ag_disp[11]}}, st.ag_disp, 1'b0};
        AG_PC_REG: next_st.ag_addr = st.pc + base;
        default: next_st.ag_addr = base;
      endcase
    end
    // a result write wins over the register update of the address modes
    if (WR_EN) begin
      rf.wr_en = 1'b1;
      rf.wr_sel = WR_SEL;
      rf.wr_data = WR_DATA;
    end

    // reset and exception stack sequencer
    unique case (st.state)
      ST_RST_PC: if (MEM_ACK) begin
        next_st.pc = MEM_RDATA;
        next_st.mem_addr = st.vtb + VEC_SP_OFF;
        next_st.state = ST_RST_SP;
      end
      ST_RST_SP: if (MEM_ACK) begin
        rf.wr_en = 1'b1;
        rf.wr_sel = SP_REG;
        rf.wr_data = MEM_RDATA;
        next_st.mem_req = 1'b0;
        next_st.busy = 1'b0;
        next_st.state = ST_IDLE;
      end
      ST_IDLE: if (EXC_REQ) begin
        next_st.exc_vec = EXC_VEC;
        next_st.mem_req = 1'b1;
        next_st.mem_we = 1'b1;
        next_st.mem_addr = st.sp - STACK_WORD;
        next_st.mem_wdata = st.status & SW_WRITABLE;
        next_st.busy = 1'b1;
        next_st.state = ST_PUSH_SR;
      end else if (EXC_RET) begin
        next_st.mem_req = 1'b1;
        next_st.mem_addr = st.sp;
        next_st.busy = 1'b1;
        next_st.state = ST_POP_PC;
      end
      ST_PUSH_SR: if (MEM_ACK) begin
        rf.wr_en = 1'b1;
        rf.wr_sel = SP_REG;
        rf.wr_data = st.sp - STACK_WORD;
        next_st.mem_addr = st.sp - STACK_WORD - STACK_WORD;
        next_st.mem_wdata = next_st.pc;
        next_st.state = ST_PUSH_PC;
      end
      ST_PUSH_PC: if (MEM_ACK) begin
        rf.wr_en = 1'b1;
        rf.wr_sel = SP_REG;
        rf.wr_data = st.sp - STACK_WORD;
        next_st.mem_we = 1'b0;
        next_st.mem_addr = st.vtb + {22'h0, st.exc_vec, 2'h0};
        next_st.state = ST_VEC;
      end
      ST_VEC: if (MEM_ACK) begin
        next_st.pc = MEM_RDATA;
        next_st.mem_req = 1'b0;
        next_st.busy = 1'b0;
        next_st.state = ST_IDLE;
      end
      ST_POP_PC: if (MEM_ACK) begin
        next_st.pc = MEM_RDATA;
        rf.wr_en = 1'b1;
        rf.wr_sel = SP_REG;
        rf.wr_data = st.sp + STACK_WORD;
        next_st.mem_addr = st.sp + STACK_WORD;
        next_st.state = ST_POP_SR;
      end
      ST_POP_SR: if (MEM_ACK) begin
        next_st.status = MEM_RDATA & SW_WRITABLE;
        rf.wr_en = 1'b1;
        rf.wr_sel = SP_REG;
        rf.wr_data = st.sp + STACK_WORD;
        next_st.mem_req = 1'b0;
        next_st.busy = 1'b0;
        next_st.state = ST_IDLE;
      end
    endcase

    // shadows of register 0 and 15 track the single write port
    if (rf.wr_en && rf.wr_sel == IDX_REG) begin
      next_st.r0 = rf.wr_data;
    end
    if (rf.wr_en && rf.wr_sel == SP_REG) begin
      next_st.sp = rf.wr_data;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      st <= REGS_RESET;
    end else if (CLK_EN) begin
      st <= next_st;
    end
  end

  assign REG_RDATA = st.rdata;
  assign RD_A_DATA = rf.rd_data[0];
  assign RD_B_DATA = rf.rd_data[1];
  assign AG_ADDR = st.ag_addr;
  assign AG_VALID = st.ag_valid;
  assign MEM_REQ = st.mem_req;
  assign MEM_WE = st.mem_we;
  assign MEM_ADDR = st.mem_addr;
  assign MEM_WDATA = st.mem_wdata;
  assign BUSY = st.busy;
  assign STATUS_WORD = st.status;
  assign PERIPH_BASE = st.pbp;
  assign VECTOR_BASE = st.vtb;
  assign MAC_HI = st.multiply_accum_high;
  assign MAC_LO = st.multiply_accum_low;
  assign LINK_REG = st.link;
  assign PC = st.pc;
  assign SP = st.sp;

  // first cycle after reset release, for the assertions only
  logic just_out;
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      just_out <= 1'b1;
    end else begin
      just_out <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  a_reserved_zero: assert property ((STATUS_WORD & ~SW_WRITABLE) == '0)
    else $error("reserved status bits not zero");
  a_mask_reset: assert property (just_out |-> STATUS_WORD[7:4] == 4'hF)
    else $error("interrupt mask not all ones after reset");
  a_reset_vector: assert property (just_out |-> MEM_REQ && !MEM_WE && MEM_ADDR == VEC_PC_OFF)
    else $error("reset does not fetch the pc vector");
  a_pbp_write: assert property (CLK_EN && REG_WR && REG_ADDR == OFF_PBP
    |=> PERIPH_BASE == $past(REG_WDATA))
    else $error("peripheral base write lost");
  a_vtb_read: assert property (CLK_EN && REG_RD && REG_ADDR == OFF_VTB
    |=> REG_RDATA == VECTOR_BASE)
    else $error("vector base read data wrong");
  a_write_forward: assert property (CLK_EN && WR_EN && RD_A_SEL == WR_SEL && st.state == ST_IDLE
    |=> RD_A_DATA == $past(WR_DATA))
    else $error("operand read misses same-cycle write");
  a_index_sum: assert property (CLK_EN && st.ag_pend && st.ag_mode == AG_INDEX
    |=> AG_VALID && AG_ADDR == $past(index_sum))
    else $error("indexed address not r0 plus register");
  a_ag_latency: assert property (CLK_EN && AG_REQ ##1 CLK_EN |=> AG_VALID)
    else $error("address not ready two cycles after request");
  a_push_status: assert property (st.state == ST_PUSH_SR
    |-> MEM_WE && MEM_ADDR == SP - STACK_WORD && MEM_WDATA == STATUS_WORD)
    else $error("status push address or data wrong");
  a_push_sp: assert property (CLK_EN && st.state == ST_PUSH_PC && MEM_ACK
    |=> SP == $past(SP) - STACK_WORD && st.state == ST_VEC)
    else $error("stack pointer not decremented on pc push");

  c_exc_entry: cover property (st.state == ST_IDLE && EXC_REQ && CLK_EN ##[1:40] st.state == ST_VEC);
  c_exc_return: cover property (st.state == ST_POP_SR && MEM_ACK && CLK_EN);
  c_postinc: cover property (CLK_EN && st.ag_pend && st.ag_mode == AG_POSTINC);
  c_reg_read: cover property (CLK_EN && REG_RD && REG_ADDR == OFF_STATUS);
endmodule // cpu_register_set

/* File: hw/cpu_regs_pkg.sv */
/*
  Constants and types shared by the CPU register set and its register store.
  Assumes a single CPU clock domain; all offsets are byte addresses on the
  control register port.
*/
package cpu_regs_pkg;
  localparam int XLEN = 32;
  localparam int NREG = 16;
  localparam int SELW = 4;
  localparam logic [SELW-1:0] IDX_REG = 4'h0;
  localparam logic [SELW-1:0] SP_REG = 4'hF;

  // control register port map
  localparam int AW = 8;
  localparam logic [AW-1:0] OFF_STATUS = 8'h00;
  localparam logic [AW-1:0] OFF_PBP = 8'h04;
  localparam logic [AW-1:0] OFF_VTB = 8'h08;
  localparam logic [AW-1:0] OFF_MULTIPLY_ACCUM_HIGH = 8'h0C;
  localparam logic [AW-1:0] OFF_MULTIPLY_ACCUM_LOW = 8'h10;
  localparam logic [AW-1:0] OFF_LINK = 8'h14;
  localparam logic [AW-1:0] OFF_PC = 8'h18;
  localparam logic [AW-1:0] OFF_SP = 8'h1C;

  // status word layout
  localparam int SW_M_BIT = 9;
  localparam int SW_Q_BIT = 8;
  localparam int SW_MASK_LSB = 4;
  localparam int SW_MASK_MSB = 7;
  localparam int SW_S_BIT = 1;
  localparam int SW_T_BIT = 0;
  localparam logic [XLEN-1:0] SW_WRITABLE = 32'h0000_03F3;
  localparam logic [XLEN-1:0] SW_RESET = 32'h0000_00F0;

  // reset values and stack/vector layout
  localparam logic [XLEN-1:0] VTB_RESET = 32'h0000_0000;
  localparam logic [XLEN-1:0] VEC_PC_OFF = 32'h0000_0000;
  localparam logic [XLEN-1:0] VEC_SP_OFF = 32'h0000_0004;
  localparam logic [XLEN-1:0] STACK_WORD = 32'h0000_0004;
  localparam logic [XLEN-1:0] INSN_BYTES = 32'h0000_0002;

  typedef enum logic [3:0] {
    AG_INDIRECT = 4'h0,
    AG_POSTINC = 4'h1,
    AG_PREDEC = 4'h2,
    AG_DISP4 = 4'h3,
    AG_INDEX = 4'h4,
    AG_PBP_DISP = 4'h5,
    AG_PBP_INDEX = 4'h6,
    AG_PC_DISP8 = 4'h7,
    AG_PC_DISP12 = 4'h8,
    AG_PC_REG = 4'h9
  } ag_mode_e;

  typedef enum logic [7:0] {
    ST_RST_PC = 8'h01,
    ST_RST_SP = 8'h02,
    ST_IDLE = 8'h04,
    ST_PUSH_SR = 8'h08,
    ST_PUSH_PC = 8'h10,
    ST_VEC = 8'h20,
    ST_POP_PC = 8'h40,
    ST_POP_SR = 8'h80
  } seq_state_e;
endpackage

/* File: hw/regfile_if.sv */
/*
  Bundle between the register set and its general register store.
  Assumes both ends share the CPU clock.
*/
`timescale 1ns/10ps
interface regfile_if #(parameter int W = 32, parameter int NRD = 3);
  logic ce;
  logic wr_en;
  logic [3:0] wr_sel;
  logic [W-1:0] wr_data;
  logic [NRD-1:0][3:0] rd_sel;
  logic [NRD-1:0][W-1:0] rd_data;
  modport owner (output ce, output wr_en, output wr_sel, output wr_data, output rd_sel,
                 input rd_data);
  modport store (input ce, input wr_en, input wr_sel, input wr_data, input rd_sel,
                 output rd_data);
endinterface

/* File: hw/gp_reg_store.sv */
/*
  Sixteen general registers with NRD registered read ports and one write port.
  Assumes the owner keeps ce low to freeze the store; reads see a write made
  in the same cycle (write-through).
*/
`timescale 1ns/10ps
module gp_reg_store #(
  parameter int W = 32,
  parameter int NREG = 16,
  parameter int NRD = 3
) (
  input wire logic clk,
  input wire logic resetn,
  regfile_if.store rf
);
  typedef struct packed {
    logic [NREG-1:0][W-1:0] regs;
    logic [NRD-1:0][W-1:0] rd;
  } store_s;

  store_s st;
  store_s next_st;

  always_comb begin
    next_st = st;
    if (rf.wr_en) begin
      next_st.regs[rf.wr_sel] = rf.wr_data;
    end
    // forwarding keeps a read in the same cycle as a write from seeing stale data
    for (int i = 0; i < NRD; i++) begin
      next_st.rd[i] = (rf.wr_en && rf.wr_sel == rf.rd_sel[i]) ? rf.wr_data
                                                             : st.regs[rf.rd_sel[i]];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else if (rf.ce) begin
      st <= next_st;
    end
  end

  assign rf.rd_data = st.rd;
endmodule // gp_reg_store

/* File: verif/mem_model.sv */
/*
  Memory at the far side of the register set: stack pushes, pops, vector reads.
  Assumes the requester holds every request signal until ack; lat adds waits.
*/
`timescale 1ns/10ps
module mem_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic req,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [1:0] lat,
  output logic ack,
  output logic [31:0] rdata
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] last;
  logic [1:0] cnt;
  // a released data bus shows the inverse, so stale data never looks valid
  assign rdata = ack ? last : ~last;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack <= 1'b0;
      cnt <= 2'h0;
      last <= 32'h0;
    end else if (ack) begin
      ack <= 1'b0;
      cnt <= lat;
    end else if (req && cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
    end else if (req) begin
      ack <= 1'b1;
      if (we) begin
        mem[addr] = wdata;
      end else begin
        last <= mem.exists(addr) ? mem[addr] : ~addr;
      end
    end
  end
endmodule // mem_model

/* File: verif/cpu_register_set_bench.sv */
/*
  Self-checking bench for the CPU register set with a memory model behind it.
  Assumes a 25 MHz CPU clock and the register port timing of the hand-over.
*/
`timescale 1ns/10ps
module cpu_register_set_bench;
  import cpu_regs_pkg::*;
  logic clk, rstn, reg_wr, reg_rd, wr_en, cond_we, cond_in, div_we, div_q, div_m;
  logic mac_we, link_we, pc_step, pc_load, ag_req, exc_req, exc_ret, mem_ack, busy;
  logic ag_valid, mem_req, mem_we, rd_d, op_chk, op_d, ce;
  logic [7:0] reg_addr, exc_vec;
  logic [3:0] sel_a, sel_b, wr_sel, ag_reg;
  logic [11:0] ag_disp;
  logic [1:0] ag_size, mem_lat;
  ag_mode_e ag_mode;
  logic [31:0] reg_wdata, reg_rdata, rd_a, rd_b, wr_data, mac_hi_in, mac_lo_in, link_in;
  logic [31:0] pc_ld, ag_addr, mem_addr, mem_wdata, mem_rdata, status, pbp, vtb;
  logic [31:0] multiply_accum_high, multiply_accum_low, link, pc, sp, pcv, spv, stv, pbpv, vtbv, v, h;
  logic [31:0] gpr [16];
  logic [31:0] exp_rd [$];
  logic [31:0] exp_ag [$];
  logic [31:0] exp_op [$];
  int n_mismatch, n_compared;

  cpu_register_set DUT (.CLK_SYS(clk), .RESETN(rstn), .CLK_EN(ce), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .RD_A_SEL(sel_a), .RD_B_SEL(sel_b), .RD_A_DATA(rd_a), .RD_B_DATA(rd_b), .WR_EN(wr_en),
    .WR_SEL(wr_sel), .WR_DATA(wr_data), .COND_WE(cond_we), .COND_IN(cond_in),
    .DIV_WE(div_we), .DIV_Q_IN(div_q), .DIV_M_IN(div_m), .MAC_WE(mac_we),
    .MAC_HI_IN(mac_hi_in), .MAC_LO_IN(mac_lo_in), .LINK_WE(link_we), .LINK_IN(link_in),
    .PC_STEP(pc_step), .PC_LOAD(pc_load), .PC_LOAD_VAL(pc_ld), .AG_REQ(ag_req),
    .AG_MODE(ag_mode), .AG_REG(ag_reg), .AG_DISP(ag_disp), .AG_SIZE(ag_size),
    .AG_ADDR(ag_addr), .AG_VALID(ag_valid), .EXC_REQ(exc_req), .EXC_VEC(exc_vec),
    .EXC_RET(exc_ret), .MEM_REQ(mem_req), .MEM_WE(mem_we), .MEM_ADDR(mem_addr),
    .MEM_WDATA(mem_wdata), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata), .BUSY(busy),
    .STATUS_WORD(status), .PERIPH_BASE(pbp), .VECTOR_BASE(vtb), .MAC_HI(multiply_accum_high),
    .MAC_LO(multiply_accum_low), .LINK_REG(link), .PC(pc), .SP(sp));
  mem_model u_mem (.clk(clk), .resetn(rstn), .req(mem_req), .we(mem_we), .addr(mem_addr),
    .wdata(mem_wdata), .lat(mem_lat), .ack(mem_ack), .rdata(mem_rdata));

  task automatic test_done();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic take(ref logic [31:0] q [$], input logic [31:0] got);
    if (q.size() == 0) begin
      // no note pending: an unknown output must not slip through
      cmp_word(32'h0, 32'h1);
    end else begin
      cmp_word(got, q.pop_front());
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  task automatic wait_idle();
    int k;
    for (k = 0; k < 300; k++) begin
      @(negedge clk);
      if (busy === 1'b0) break;
    end
    if (k == 300) begin
      n_mismatch++;
      test_done();
    end
  endtask

  task automatic exc(input logic ret, input logic [7:0] vec);
    @(posedge clk);
    exc_req <= ~ret;
    exc_ret <= ret;
    exc_vec <= vec;
    mem_lat <= 2'($urandom);
    @(posedge clk);
    exc_req <= 1'b0;
    exc_ret <= 1'b0;
    wait_idle();
  endtask

  function automatic logic [31:0] ag_exp(ag_mode_e m, logic [3:0] n, logic [11:0] d,
                                         logic [1:0] z);
    logic [31:0] s;
    s = 32'h1 << z;
    case (m)
      AG_INDIRECT, AG_POSTINC: ag_exp = gpr[n];
      AG_PREDEC: ag_exp = gpr[n] - s;
      AG_DISP4: ag_exp = gpr[n] + {28'h0, d[3:0]} * s;
      AG_INDEX: ag_exp = gpr[0] + gpr[n];
      AG_PBP_DISP: ag_exp = pbpv + {24'h0, d[7:0]} * s;
      AG_PBP_INDEX: ag_exp = pbpv + gpr[0];
      AG_PC_DISP8: ag_exp = pcv + {{23{d[7]}}, d[7:0], 1'b0};
      AG_PC_DISP12: ag_exp = pcv + {{19{d[11]}}, d, 1'b0};
      default: ag_exp = pcv + gpr[n];
    endcase
  endfunction

  // results are judged half a cycle after the edge that produced them
  always @(posedge clk) begin
    rd_d <= reg_rd;
    op_d <= op_chk;
  end
  always @(negedge clk) begin
    if (rd_d) take(exp_rd, reg_rdata);
    if (ag_valid === 1'b1) take(exp_ag, ag_addr);
    if (op_d) begin
      take(exp_op, rd_a);
      take(exp_op, rd_b);
    end
  end

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    logic [7:0] offs [6];
    logic [31:0] vals [6];
    logic [3:0] n, b;
    logic [1:0] z;
    logic [11:0] d;
    ag_mode_e m;
    offs = '{OFF_PBP, OFF_VTB, OFF_MULTIPLY_ACCUM_HIGH, OFF_MULTIPLY_ACCUM_LOW, OFF_LINK, OFF_PC};
    {rstn, reg_wr, reg_rd, wr_en, cond_we, cond_in, div_we, div_q, div_m} = '0;
    {mac_we, link_we, pc_step, pc_load, ag_req, exc_req, exc_ret, op_chk} = '0;
    {reg_addr, exc_vec, sel_a, sel_b, wr_sel, ag_reg, ag_disp, ag_size, mem_lat} = '0;
    {reg_wdata, wr_data, mac_hi_in, mac_lo_in, link_in, pc_ld} = '0;
    ag_mode = AG_INDIRECT;
    ce = 1'b1;
    n_mismatch = 0;
    n_compared = 0;
    void'($urandom(32'hb794));
    pcv = $urandom;
    spv = $urandom & 32'hFFFF_FFFC;
    u_mem.mem[32'h0] = pcv;
    u_mem.mem[32'h4] = spv;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    wait_idle();
    cmp_word(pc, pcv);
    cmp_word(sp, spv);
    gpr[15] = spv;
    reg_read(OFF_STATUS, 32'h0000_00F0);
    reg_read(OFF_VTB, 32'h0);
    for (int i = 0; i < 6; i++) begin
      vals[i] = $urandom;
      reg_write(offs[i], vals[i]);
      reg_read(offs[i], vals[i]);
    end
    pbpv = vals[0];
    vtbv = vals[1];
    cmp_word(pbp, pbpv);
    cmp_word(vtb, vtbv);
    pcv = vals[5];
    reg_write(OFF_SP, ~spv);
    reg_read(OFF_SP, spv);
    reg_write(8'h20, 32'hFFFF_FFFF);
    reg_read(8'h20, 32'h0);
    stv = $urandom & 32'h0000_03F3;
    reg_write(OFF_STATUS, stv);
    reg_read(OFF_STATUS, stv);
    vals[0] = $urandom;
    vals[1] = $urandom;
    @(posedge clk);
    {cond_we, div_we, mac_we, link_we} <= 4'hF;
    {div_m, div_q, cond_in} <= ~{stv[9], stv[8], stv[0]};
    {mac_hi_in, mac_lo_in, link_in} <= {vals[0], vals[1], ~vals[0]};
    @(posedge clk);
    {cond_we, div_we, mac_we, link_we} <= 4'h0;
    stv = stv ^ 32'h0000_0301;
    reg_read(OFF_STATUS, stv);
    reg_read(OFF_MULTIPLY_ACCUM_HIGH, vals[0]);
    reg_read(OFF_MULTIPLY_ACCUM_LOW, vals[1]);
    reg_read(OFF_LINK, ~vals[0]);
    cmp_word(multiply_accum_high, vals[0]);
    cmp_word(multiply_accum_low, vals[1]);
    cmp_word(link, ~vals[0]);
    @(posedge clk);
    pc_step <= 1'b1;
    @(posedge clk);
    pc_step <= 1'b0;
    reg_read(OFF_PC, pcv + 32'h2);
    pcv = $urandom;
    @(posedge clk);
    {pc_step, pc_load} <= 2'h3;
    pc_ld <= pcv;
    @(posedge clk);
    {pc_step, pc_load} <= 2'h0;
    reg_read(OFF_PC, pcv);
    // clock enable low freezes the pc although a step is asked for
    @(posedge clk);
    {ce, pc_step} <= 2'h1;
    repeat (3) @(posedge clk);
    {ce, pc_step} <= 2'h2;
    reg_read(OFF_PC, pcv);
    // one write and two reads per cycle, the write read back at once
    for (int i = 0; i < 15; i++) begin
      v = $urandom;
      b = 4'(i) - 4'h1;
      exp_op.push_back(v);
      exp_op.push_back(gpr[b]);
      @(posedge clk);
      {wr_en, op_chk} <= 2'h3;
      {wr_sel, sel_a, sel_b} <= {4'(i), 4'(i), b};
      wr_data <= v;
      gpr[i] = v;
    end
    @(posedge clk);
    {wr_en, op_chk} <= 2'h0;
    repeat (2) begin
      for (int i = 0; i < 10; i++) begin
        m = ag_mode_e'(i);
        n = 4'($urandom_range(1, 14));
        d = 12'($urandom);
        z = 2'($urandom_range(0, 2));
        exp_ag.push_back(ag_exp(m, n, d, z));
        @(posedge clk);
        ag_req <= 1'b1;
        ag_mode <= m;
        {ag_reg, ag_disp, ag_size} <= {n, d, z};
        @(posedge clk);
        ag_req <= 1'b0;
        if (m == AG_POSTINC) gpr[n] = gpr[n] + (32'h1 << z);
        if (m == AG_PREDEC) gpr[n] = gpr[n] - (32'h1 << z);
      end
      repeat (3) @(posedge clk);
    end
    for (int i = 0; i < 16; i++) begin
      exp_op.push_back(gpr[i]);
      exp_op.push_back(gpr[15 - i]);
      @(posedge clk);
      op_chk <= 1'b1;
      {sel_a, sel_b} <= {4'(i), 4'(15 - i)};
      @(posedge clk);
      op_chk <= 1'b0;
    end
    n = 4'($urandom);
    h = $urandom;
    u_mem.mem[vtbv + {22'h0, n, 2'h0}] = h;
    exc(1'b0, {4'h0, n});
    cmp_word(u_mem.mem[spv - 32'h4], stv);
    cmp_word(u_mem.mem[spv - 32'h8], pcv);
    cmp_word(pc, h);
    cmp_word(sp, spv - 32'h8);
    exc(1'b1, 8'h0);
    cmp_word(pc, pcv);
    cmp_word(sp, spv);
    cmp_word(status, stv);
    repeat (4) @(posedge clk);
    if (exp_rd.size() + exp_ag.size() + exp_op.size() != 0) n_mismatch++;
    test_done();
  end
endmodule // cpu_register_set_bench
